//--- logic/tsrb_bank.sv
// Sensor register bank with two-wire serial slave and conversion scheduler
`timescale 1ns/100ps
`include "tsrb_defines.svh"
module tsrb_bank #(
    parameter int unsigned RATE1_CYC    = 32'(`TSRB_US2CYC(`TSRB_RATE1_US)),
    parameter int unsigned RATE2_CYC    = 32'(`TSRB_US2CYC(`TSRB_RATE2_US)),
    parameter int unsigned RATE3_CYC    = 32'(`TSRB_US2CYC(`TSRB_RATE3_US)),
    parameter int unsigned CONV_FLT_CYC = 32'(`TSRB_US2CYC(`TSRB_CONV_FLT_US)),
    parameter int unsigned CONV_OK_CYC  = 32'(`TSRB_US2CYC(`TSRB_CONV_OK_US)),
    parameter int unsigned PWRUP_CYC    = 32'(`TSRB_US2CYC(`TSRB_PWRUP_US)),
    parameter logic [6:0]  ADDR_LO      = 7'h2A,  // arbitrary
    parameter logic [6:0]  ADDR_HI      = 7'h2B   // arbitrary
) (
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic                 smb_clk,
    input  wire logic                 smb_dat_in,
    output logic                      smb_dat_out,
    output logic                      smb_dat_oe,
    input  wire logic                 os_pin_in,
    output logic                      os_pin_out,
    output logic                      os_pin_oe,
    output logic                      crit_output_n,
    input  tsrb_pkg::tsrb_temps_s     temps_in,
    input  wire logic                 diode_fault_in,
    input  wire logic                 discrete_detect_in,
    output logic                      conv_active,
    output logic                      diode_model_select,
    output logic                      remote_filter_sel_hi,
    output logic                      remote_filter_sel_lo,
    output logic [15:0]               remote_offset
);
    import tsrb_pkg::*;

    // Folds the aliased addresses onto one register each
    function automatic logic [7:0] fold_alias(input logic [7:0] a);
        unique case (a)
            `TSRB_OFS_CFG1_ALT: fold_alias = `TSRB_OFS_CFG1;
            `TSRB_OFS_RATE_ALT: fold_alias = `TSRB_OFS_RATE;
            `TSRB_OFS_ROS_ALT:  fold_alias = `TSRB_OFS_ROS;
            default:            fold_alias = a;
        endcase
    endfunction

    // Limit flag with hysteresis; holds between the two thresholds
    function automatic logic hyst_flag(input logic cur, input logic [7:0] t,
                                       input logic [7:0] lim, input logic [4:0] h);
        logic [8:0] low;
        low = {1'b0, lim} - {4'h0, h};
        if (t > lim)
            hyst_flag = 1'b1;
        else if (low[8] || ({1'b0, t} < low))
            hyst_flag = cur && low[8] ? cur : 1'b0;
        else
            hyst_flag = cur;
    endfunction

    // Registers written by the host
    logic [7:0]  diag_q, cfg1_q, ros_q, rcrit_q, loclim_q, offhi_q, offlo_q;
    logic [1:0]  rate_q;
    logic [4:0]  hyst_q;
    // Conversion state
    logic        busy_q, ros_f_q, rcrit_f_q, loc_f_q, flt_q;
    logic [24:0] conv_cnt_q, wait_cnt_q, pwr_cnt_q;
    tsrb_temps_s tmp_q;
    // Serial slave state
    logic [2:0]  ff1_q, ff2_q, ff3_q, filt_q, prev_q;
    tsrb_state_e st_q;
    logic [3:0]  bit_q;
    logic [7:0]  sh_q, ptr_q, tx_q;
    logic [1:0]  phase_q;
    logic        rnw_q, mack_q, sda_oe_q, os_oe_q, crit_q;
    logic [2:0]  lock_q;
    logic [7:0]  frz_q [3];

    // Pin sampling: filtered level moves once stages two and three agree
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ff1_q  <= 3'h7;
            ff2_q  <= 3'h7;
            ff3_q  <= 3'h7;
            filt_q <= 3'h7;
            prev_q <= 3'h7;
        end else begin
            ff1_q  <= {os_pin_in, smb_clk, smb_dat_in};
            ff2_q  <= ff1_q;
            ff3_q  <= ff2_q;
            filt_q <= (ff2_q & ff3_q) | (filt_q & (ff2_q ^ ff3_q));
            prev_q <= filt_q;
        end
    end

    // Bus events from the filtered levels
    wire scl_f    = filt_q[1];
    wire sda_f    = filt_q[0];
    wire scl_rise = scl_f & ~prev_q[1];
    wire scl_fall = ~scl_f & prev_q[1];
    wire start_ev = scl_f & prev_q[1] & prev_q[0] & ~sda_f;
    wire stop_ev  = scl_f & prev_q[1] & ~prev_q[0] & sda_f;
    wire pin_sel  = diag_q[`TSRB_DIAG_PIN];
    wire [6:0] my_addr = (~pin_sel & filt_q[2]) ? ADDR_HI : ADDR_LO;
    wire byte_end = scl_fall & (st_q == ST_RX) & (bit_q == 4'h8);
    wire rd_stb   = scl_fall & (((st_q == ST_ACK) & rnw_q) | ((st_q == ST_MACK) & mack_q));
    wire wr_stb   = byte_end & (phase_q == 2'h2);
    wire [7:0] rd_a = fold_alias(ptr_q);
    wire [7:0] wr_a = fold_alias(ptr_q);
    logic [7:0] rd_val;

    // Serial slave: address, command, data bytes; reads repeat the pointer
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            tx_q <= 8'h00;
            phase_q <= 2'h0;
            rnw_q <= 1'b0;
            mack_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (start_ev) begin
            st_q <= ST_RX;
            bit_q <= 4'h0;
            phase_q <= 2'h0;
            sda_oe_q <= 1'b0;
        end else if (stop_ev) begin
            st_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_f};
                        bit_q <= bit_q + 4'h1;
                    end else if (byte_end) begin
                        // A foreign address is not answered
                        if (phase_q == 2'h0 && sh_q[7:1] != my_addr) begin
                            st_q <= ST_IDLE;
                        end else begin
                            st_q <= ST_ACK;
                            sda_oe_q <= 1'b1;
                        end
                        if (phase_q == 2'h0)
                            rnw_q <= sh_q[0];
                        if (phase_q == 2'h1)
                            ptr_q <= sh_q;
                        if (phase_q != 2'h2)
                            phase_q <= phase_q + 2'h1;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_q <= 4'h0;
                        st_q <= rnw_q ? ST_TX : ST_RX;
                        tx_q <= rd_val;
                        sda_oe_q <= rnw_q & ~rd_val[7];
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 4'h1;
                        tx_q <= {tx_q[6:0], 1'b0};
                        st_q <= (bit_q == 4'h7) ? ST_MACK : ST_TX;
                        sda_oe_q <= (bit_q != 4'h7) & ~tx_q[6];
                    end
                end
                ST_MACK: begin
                    if (scl_rise)
                        mack_q <= ~sda_f;
                    else if (scl_fall) begin
                        bit_q <= 4'h0;
                        st_q <= mack_q ? ST_TX : ST_IDLE;
                        tx_q <= rd_val;
                        sda_oe_q <= mack_q & ~rd_val[7];
                    end
                end
            endcase
        end
    end
    assign smb_dat_out = 1'b0;
    assign smb_dat_oe  = sda_oe_q;

    // Register writes; reserved bits are forced so they read back fixed
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            diag_q <= `TSRB_RST_DIAG;
            cfg1_q <= `TSRB_RST_CFG1;
            rate_q <= `TSRB_RST_RATE;
            ros_q <= `TSRB_RST_ROS;
            rcrit_q <= `TSRB_RST_RCRIT;
            loclim_q <= `TSRB_RST_LOCLIM;
            hyst_q <= `TSRB_RST_HYST;
            offhi_q <= `TSRB_RST_OFF;
            offlo_q <= `TSRB_RST_OFF;
        end else if (wr_stb) begin
            unique case (wr_a)
                `TSRB_OFS_DIAG:   diag_q <= {1'b0, sh_q[6:1], 1'b1};
                `TSRB_OFS_CFG1:   cfg1_q <= sh_q & `TSRB_CFG1_WMASK;
                `TSRB_OFS_RATE:   rate_q <= sh_q[1:0];
                `TSRB_OFS_ROS:    ros_q <= sh_q;
                `TSRB_OFS_RCRIT:  rcrit_q <= sh_q;
                `TSRB_OFS_LOCLIM: loclim_q <= sh_q;
                `TSRB_OFS_HYST:   hyst_q <= sh_q[4:0];
                `TSRB_OFS_OFF_HI: offhi_q <= sh_q;
                `TSRB_OFS_OFF_LO: offlo_q <= sh_q & `TSRB_OFFLO_WMASK;
                default: ;
            endcase
        end
    end

    // Front-end controls
    assign diode_model_select   = diag_q[`TSRB_DIAG_MODEL];
    assign remote_filter_sel_hi = diag_q[2];
    assign remote_filter_sel_lo = diag_q[1];
    assign remote_offset        = {offhi_q, offlo_q};
    assign conv_active          = busy_q;

    // Conversion scheduling terms
    wire stby      = cfg1_q[`TSRB_CFG1_STBY];
    wire not_ready = (pwr_cnt_q != 25'h0);
    wire oneshot   = wr_stb & (wr_a == `TSRB_OFS_ONESHOT);
    wire conv_go   = ~busy_q & ~not_ready &
                     (stby ? oneshot : (wait_cnt_q == 25'h0));
    wire conv_end  = busy_q & (conv_cnt_q == 25'h1);
    wire filt_on   = diag_q[2] & diag_q[1];
    wire [7:0] fmask = filt_on ? 8'hF8 : 8'hE0;
    logic [24:0] ivl;

    // Interval per rate code, less the reload clock so starts sit exactly one interval apart
    always_comb begin
        unique case (rate_q)
            2'h0: ivl = 25'h0;
            2'h1: ivl = 25'(RATE1_CYC - 1);
            2'h2: ivl = 25'(RATE2_CYC - 1);
            2'h3: ivl = 25'(RATE3_CYC - 1);
        endcase
    end

    // Power-up wait, busy window and interval timer
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pwr_cnt_q <= 25'(PWRUP_CYC);
            busy_q <= 1'b0;
            conv_cnt_q <= 25'h0;
            wait_cnt_q <= 25'h0;
        end else begin
            if (not_ready)
                pwr_cnt_q <= pwr_cnt_q - 25'h1;
            if (wait_cnt_q != 25'h0)
                wait_cnt_q <= wait_cnt_q - 25'h1;
            if (conv_go) begin
                busy_q <= 1'b1;
                conv_cnt_q <= diode_fault_in ? 25'(CONV_FLT_CYC)
                                             : 25'(CONV_OK_CYC);
                wait_cnt_q <= ivl;
            end else if (busy_q) begin
                conv_cnt_q <= conv_cnt_q - 25'h1;
                busy_q <= ~conv_end;
            end
        end
    end

    // Results and limit flags at the end of each conversion
    wire [7:0] loc_t = tmp_q.local_msb[7] ? 8'h00 : tmp_q.local_msb;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tmp_q <= '0;
            flt_q <= 1'b0;
            ros_f_q <= 1'b0;
            rcrit_f_q <= 1'b0;
            loc_f_q <= 1'b0;
        end else if (conv_end) begin
            tmp_q <= temps_in;
            flt_q <= diode_fault_in;
            if (diode_fault_in) begin
                tmp_q.rsig_msb <= 8'h80;
                tmp_q.rsig_lsb <= 8'h00;
                tmp_q.runs_msb <= 8'h00;
                tmp_q.runs_lsb <= 8'h00;
            end
            ros_f_q <= hyst_flag(ros_f_q, temps_in.runs_msb, ros_q, hyst_q);
            rcrit_f_q <= hyst_flag(rcrit_f_q, temps_in.runs_msb, rcrit_q, hyst_q);
            loc_f_q <= hyst_flag(loc_f_q, temps_in.local_msb[7] ? 8'h00
                                 : temps_in.local_msb, loclim_q, hyst_q);
        end
    end

    // Low-byte freeze per temperature pair
    wire [7:0] msb_ofs [3] = '{`TSRB_OFS_LT_MSB, `TSRB_OFS_RS_MSB, `TSRB_OFS_RU_MSB};
    wire [7:0] lsb_ofs [3] = '{`TSRB_OFS_LT_LSB, `TSRB_OFS_RS_LSB, `TSRB_OFS_RU_LSB};
    wire [7:0] lsb_cur [3] = '{tmp_q.local_lsb, tmp_q.rsig_lsb & fmask,
                                tmp_q.runs_lsb & fmask};
    wire [7:0] lsb_rd  [3];
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pair
            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    lock_q[gi] <= 1'b0;
                    frz_q[gi] <= 8'h00;
                end else if (rd_stb && rd_a == msb_ofs[gi]) begin
                    lock_q[gi] <= 1'b1;
                    frz_q[gi] <= lsb_cur[gi];
                end else if (rd_stb && rd_a == lsb_ofs[gi]) begin
                    lock_q[gi] <= 1'b0;
                end
            end
            assign lsb_rd[gi] = lock_q[gi] ? frz_q[gi] : lsb_cur[gi];
        end
    endgenerate

    // Read data; unmapped and write-only addresses read zero
    always_comb begin
        unique case (rd_a)
            `TSRB_OFS_LT_MSB: rd_val = tmp_q.local_msb;
            `TSRB_OFS_RS_MSB: rd_val = tmp_q.rsig_msb;
            `TSRB_OFS_RU_MSB: rd_val = tmp_q.runs_msb;
            `TSRB_OFS_LT_LSB: rd_val = lsb_rd[0];
            `TSRB_OFS_RS_LSB: rd_val = lsb_rd[1];
            `TSRB_OFS_RU_LSB: rd_val = lsb_rd[2];
            `TSRB_OFS_STAT1:  rd_val = {busy_q, 2'b00, ros_f_q, 1'b0,
                                        flt_q, rcrit_f_q, loc_f_q};
            `TSRB_OFS_STAT2:  rd_val = {not_ready, discrete_detect_in &
                                        diode_model_select, 6'h00};
            `TSRB_OFS_DIAG:   rd_val = diag_q;
            `TSRB_OFS_CFG1:   rd_val = cfg1_q;
            `TSRB_OFS_RATE:   rd_val = {6'h00, rate_q};
            `TSRB_OFS_ROS:    rd_val = ros_q;
            `TSRB_OFS_RCRIT:  rd_val = rcrit_q;
            `TSRB_OFS_LOCLIM: rd_val = loclim_q;
            `TSRB_OFS_HYST:   rd_val = {3'h0, hyst_q};
            `TSRB_OFS_OFF_HI: rd_val = offhi_q;
            `TSRB_OFS_OFF_LO: rd_val = offlo_q;
            default:          rd_val = 8'h00;
        endcase
    end

    // Alarm outputs; masks set to 1 keep an event off its pin
    wire os_ev   = (ros_f_q & ~cfg1_q[`TSRB_CFG1_ROS_M]) | (loc_f_q & ~cfg1_q[`TSRB_CFG1_LOS_M])
                 | (flt_q & ~diag_q[`TSRB_DIAG_FM_OS]);
    wire crit_ev = (rcrit_f_q & ~cfg1_q[`TSRB_CFG1_RCRIT_M])
                 | (loc_f_q & ~cfg1_q[`TSRB_CFG1_LCRIT_M])
                 | (flt_q & ~diag_q[`TSRB_DIAG_FM_CRIT]);
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            os_oe_q <= 1'b0;
            crit_q <= 1'b0;
        end else begin
            os_oe_q <= pin_sel & os_ev;
            crit_q <= crit_ev;
        end
    end
    assign os_pin_out    = 1'b0;
    assign os_pin_oe     = os_oe_q;
    assign crit_output_n = ~crit_q;

    // Checks
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    AST_LSB_FREEZE: assert property (
        rd_stb && rd_a == `TSRB_OFS_RU_MSB |=> lock_q[2] && frz_q[2] == $past(lsb_cur[2]))
        else $error("low byte not frozen after high byte read");
    AST_LSB_RELEASE: assert property (
        rd_stb && rd_a == `TSRB_OFS_LT_LSB |=> !lock_q[0])
        else $error("low byte still frozen after its read");
    AST_DIAG_FIXED: assert property (
        rd_a == `TSRB_OFS_DIAG |-> rd_val[7] == 1'b0 && rd_val[0] == 1'b1)
        else $error("diode config fixed bits wrong");
    AST_ONESHOT_RUN: assert property (
        oneshot && stby && !busy_q && !not_ready |=> busy_q ##1 busy_q)
        else $error("one-shot in standby did not convert");
    AST_ONESHOT_IGN: assert property (
        stby && !busy_q && !oneshot |=> !busy_q)
        else $error("standby converted without one-shot");
    AST_BUSY_BIT: assert property (
        rd_a == `TSRB_OFS_STAT1 |-> rd_val[7] == busy_q && rd_val[6:5] == 2'b00)
        else $error("busy status bit wrong");
    AST_NOT_READY: assert property (
        not_ready && rd_a == `TSRB_OFS_STAT2 |-> rd_val[7] && !busy_q)
        else $error("not-ready bit or early conversion");
    AST_FAULT_READ: assert property (
        conv_end && diode_fault_in |=> tmp_q.runs_msb == 8'h00
                                     && tmp_q.rsig_msb == 8'h80 && flt_q)
        else $error("fault reading not forced");
    AST_PIN_ADDR: assert property (
        !pin_sel |=> !os_pin_oe)
        else $error("pin driven while used as address select");
endmodule

//--- logic/tsrb_defines.svh
// Register offsets, reset values, field positions and timing of the sensor bank
`ifndef TSRB_DEFINES_SVH
`define TSRB_DEFINES_SVH
// Register offsets
`define TSRB_OFS_LT_MSB    8'h00
`define TSRB_OFS_RS_MSB    8'h01
`define TSRB_OFS_STAT1     8'h02
`define TSRB_OFS_CFG1      8'h03
`define TSRB_OFS_CFG1_ALT  8'h09
`define TSRB_OFS_RATE      8'h04
`define TSRB_OFS_RATE_ALT  8'h0A
`define TSRB_OFS_ROS       8'h07
`define TSRB_OFS_ROS_ALT   8'h0D
`define TSRB_OFS_ONESHOT   8'h0F
`define TSRB_OFS_RS_LSB    8'h10
`define TSRB_OFS_OFF_HI    8'h11
`define TSRB_OFS_OFF_LO    8'h12
`define TSRB_OFS_RCRIT     8'h19
`define TSRB_OFS_LOCLIM    8'h20
`define TSRB_OFS_HYST      8'h21
`define TSRB_OFS_LT_LSB    8'h30
`define TSRB_OFS_RU_MSB    8'h31
`define TSRB_OFS_RU_LSB    8'h32
`define TSRB_OFS_STAT2     8'h33
`define TSRB_OFS_DIAG      8'hBF
// Reset values
`define TSRB_RST_DIAG      8'h1F
`define TSRB_RST_CFG1      8'h00
`define TSRB_RST_RATE      2'h2
`define TSRB_RST_ROS       8'h55
`define TSRB_RST_LOCLIM    8'h55
`define TSRB_RST_RCRIT     8'h6E
`define TSRB_RST_HYST      5'h0A
`define TSRB_RST_OFF       8'h00
// Field positions
`define TSRB_DIAG_PIN      6
`define TSRB_DIAG_FM_OS    5
`define TSRB_DIAG_FM_CRIT  4
`define TSRB_DIAG_MODEL    3
`define TSRB_CFG1_STBY     6
`define TSRB_CFG1_RCRIT_M  4
`define TSRB_CFG1_ROS_M    3
`define TSRB_CFG1_LCRIT_M  2
`define TSRB_CFG1_LOS_M    1
// Write masks
`define TSRB_CFG1_WMASK    8'h5E
`define TSRB_OFFLO_WMASK   8'hE0
// Timing, in microseconds, and the clock period in ns
`define TSRB_CLK_NS        64'd100
`define TSRB_RATE1_US      64'd364000
`define TSRB_RATE2_US      64'd1000000
`define TSRB_RATE3_US      64'd2500000
`define TSRB_CONV_FLT_US   64'd33000
`define TSRB_CONV_OK_US    64'd63000
`define TSRB_PWRUP_US      64'd30000
`define TSRB_US2CYC(us)    (((us) * 64'd1000) / `TSRB_CLK_NS)
`endif

//--- logic/tsrb_pkg.sv
// Types shared by the sensor register bank
package tsrb_pkg;
    // One conversion result set from the measurement front end
    typedef struct packed {
        logic [7:0] local_msb;
        logic [7:0] local_lsb;
        logic [7:0] rsig_msb;
        logic [7:0] rsig_lsb;
        logic [7:0] runs_msb;
        logic [7:0] runs_lsb;
    } tsrb_temps_s;
    // Serial slave states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX   = 5'b00010,
        ST_ACK  = 5'b00100,
        ST_TX   = 5'b01000,
        ST_MACK = 5'b10000
    } tsrb_state_e;
endpackage

//--- verif/tsrb_bank_bench.sv
// Self-checking bench for the sensor register bank
`timescale 1ns/100ps
module tsrb_bank_bench;
    import tsrb_pkg::*;
    logic        clock, reset, dat_oe, os_oe, crit_n, conv, model, f_hi, f_lo, fault, detect;
    logic        conv_d = 1'b0;
    logic [15:0] offset;
    tsrb_temps_s temps;
    wire         scl, pull;
    wire         sda = !(pull | dat_oe);
    int          fails = 0;
    int          checks_done = 0;
    int          starts = 0;
    int          s0;
    localparam int unsigned IVL = 20;  // Shortest interval; the slower codes are its multiples
    // Code 00: eight busy clocks and one idle clock per conversion
    int          per [4] = '{9, IVL, 2 * IVL, 3 * IVL};
    logic [15:0] tbl [14] = '{16'hBF1F, 16'h0300, 16'h0900, 16'h0402, 16'h0A02, 16'h0755,
        16'h0D55, 16'h1100, 16'h1200, 16'h196E, 16'h2055, 16'h210A, 16'h0F00, 16'h5500};
    tsrb_bank #(.RATE1_CYC(IVL), .RATE2_CYC(2 * IVL), .RATE3_CYC(3 * IVL), .CONV_FLT_CYC(5),
        .CONV_OK_CYC(8), .PWRUP_CYC(10)) i_tsrb_bank (
        .clock(clock), .reset(reset), .smb_clk(scl), .smb_dat_in(sda), .smb_dat_out(),
        .smb_dat_oe(dat_oe), .os_pin_in(!os_oe), .os_pin_out(), .os_pin_oe(os_oe),
        .crit_output_n(crit_n), .temps_in(temps), .diode_fault_in(fault),
        .discrete_detect_in(detect), .conv_active(conv), .diode_model_select(model),
        .remote_filter_sel_hi(f_hi), .remote_filter_sel_lo(f_lo), .remote_offset(offset));
    tsrb_host i_tsrb_host (.clock(clock), .sda(sda), .scl(scl), .pull(pull));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Busy edges counted here, since a short conversion ends inside a bus frame
    always @(posedge clock) begin
        conv_d <= conv;
        if (conv === 1'b1 && conv_d === 1'b0)
            starts <= starts + 1;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        i_tsrb_host.read_reg(a, d);
        chk(d & m, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_tsrb_host.write_reg(a, d);
    endtask
    task automatic complete_run();
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard, about two and a half times the length of the whole sequence
    initial begin
        #4000000;
        fails++;
        complete_run();
    end
    initial begin
        reset = 1'b1;
        fault = 1'b0;
        detect = 1'b1;
        temps = '{8'h60, 8'hA0, 8'h70, 8'h20, 8'h70, 8'h20};
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++)
            rd(tbl[i][15:8], 8'hFF, tbl[i][7:0]);
        for (int i = 7; i < 14; i++)
            rd(tbl[i][15:8], 8'hFF, tbl[i][7:0]);
        rd(8'h02, 8'h7F, 8'h13);
        chk(crit_n, 1'b0);
        rd(8'h33, 8'hFF, 8'h40);
        // Two high reads, the second refreezing a newer low byte
        for (int k = 0; k < 2; k++) begin
            rd(8'h00, 8'hFF, 8'h60);
            temps.local_lsb <= 8'hC0 + 8'(k * 32);
            repeat (100) @(posedge clock);
        end
        rd(8'h30, 8'hFF, 8'hC0);
        rd(8'h30, 8'hFF, 8'hE0);
        wr(8'hBF, 8'hFF);
        i_tsrb_host.dev_addr = i_tsrb_bank.ADDR_LO;
        rd(8'hBF, 8'hFF, 8'h7F);
        chk({os_oe, model, f_hi, f_lo}, 4'hF);
        // Detect bit must follow its input while the processor model is chosen
        detect <= 1'b0;
        rd(8'h33, 8'hFF, 8'h00);
        detect <= 1'b1;
        wr(8'hBF, 8'h00);
        i_tsrb_host.dev_addr = i_tsrb_bank.ADDR_HI;
        rd(8'hBF, 8'hFF, 8'h01);
        chk({os_oe, model, f_hi, f_lo}, 4'h0);
        wr(8'h11, 8'h85);
        wr(8'h12, 8'hFF);
        rd(8'h12, 8'hFF, 8'hE0);
        chk(offset, 16'h85E0);
        wr(8'h09, 8'hFF);
        rd(8'h03, 8'hFF, 8'h5E);
        chk(crit_n, 1'b1);
        repeat (100) @(posedge clock);
        s0 = starts;
        chk(conv, 1'b0);
        wr(8'h0F, 8'h5A);
        repeat (40) @(posedge clock);
        chk(16'(starts - s0), 16'd1);
        wr(8'h03, 8'h00);
        // Each rate code gives exactly ten starts in a ten-interval window
        for (int c = 0; c < 4; c++) begin
            wr(8'h04, 8'hFC | 8'(c));
            rd(8'h04, 8'hFF, 8'(c));
            repeat (70) @(posedge clock);
            s0 = starts;
            repeat (10 * per[c]) @(posedge clock);
            chk(16'(starts - s0), 16'd10);
        end
        fault <= 1'b1;
        repeat (200) @(posedge clock);
        rd(8'h02, 8'h04, 8'h04);
        rd(8'h31, 8'hFF, 8'h00);
        rd(8'h01, 8'hFF, 8'h80);
        complete_run();
    end
endmodule

//--- verif/tsrb_host.sv
// Two-wire bus host model issuing register writes and reads
`timescale 1ns/100ps
module tsrb_host (
    input  wire logic clock,
    input  wire logic sda,
    output logic      scl,
    output logic      pull
);
    logic [6:0] dev_addr = 7'h2B;
    // Bus released; its clock stands high between frames
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    task automatic hw(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Clock held low six clocks: the bank turns its data line five clocks after a fall
    task automatic xbit(input logic b, output logic r);
        hw(1);
        pull <= !b;
        hw(5);
        scl <= 1'b1;
        hw(2);
        r = sda;
        scl <= 1'b0;
    endtask
    task automatic start();
        hw(1);
        pull <= 1'b0;
        hw(5);
        scl <= 1'b1;
        hw(4);
        pull <= 1'b1;
        hw(4);
        scl <= 1'b0;
    endtask
    task automatic stop();
        hw(1);
        pull <= 1'b1;
        hw(5);
        scl <= 1'b1;
        hw(4);
        pull <= 1'b0;
        hw(4);
    endtask
    // Ninth bit released: ACK from the bank, or NACK from us after read data
    task automatic xbyte(input logic [7:0] d, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--)
            xbit(d[i], r[i]);
        xbit(1'b1, a);
    endtask
    task automatic write_reg(input logic [7:0] cmd, input logic [7:0] d);
        logic [7:0] r;
        start();
        xbyte({dev_addr, 1'b0}, r);
        xbyte(cmd, r);
        xbyte(d, r);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] cmd, output logic [7:0] d);
        logic [7:0] r;
        start();
        xbyte({dev_addr, 1'b0}, r);
        xbyte(cmd, r);
        start();
        xbyte({dev_addr, 1'b1}, r);
        xbyte(8'hFF, d);
        stop();
    endtask
endmodule
